// File: isib_pkg.sv
// package: register map, field positions, reset values and states of the i2c slave block
`default_nettype none
package isib_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 4;
    localparam int REG_W  = 16;

    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_BUFFER   = 4'h0;
    localparam logic [3:0] IDX_STATUS   = 4'h1;
    localparam logic [3:0] IDX_IRQ_EN   = 4'h2;
    localparam logic [3:0] IDX_CONTROL  = 4'h3;
    localparam logic [3:0] IDX_OWN_ADDR = 4'hF;

    // event flag and enable positions (shared layout)
    localparam int BIT_START  = 0;
    localparam int BIT_TX     = 1;
    localparam int BIT_RX     = 2;
    localparam int BIT_STR    = 3;
    localparam int BIT_TO     = 4;
    localparam int BIT_AM     = 5;
    localparam int BIT_NACK   = 7;
    localparam int BIT_GC     = 8;
    localparam int BIT_ROV    = 9;
    localparam int BIT_SCL    = 10;
    localparam int BIT_STOP   = 11;
    localparam int BIT_ACTIVE = 14;
    localparam int BIT_BUS    = 15;

    localparam logic [15:0] EVENT_MASK       = 16'h0BBF;
    localparam logic [15:0] FLAG_SW_SET_MASK = 16'h0B33;
    localparam logic [15:0] FLAG_SW_CLR_MASK = 16'h09BF;

    // control register fields
    localparam int CTL_ACK     = 0;
    localparam int CTL_GC_EN   = 1;
    localparam int CTL_STRETCH = 2;
    localparam logic [2:0] CONTROL_RESET = 3'h0;

    localparam logic [6:0] OWN_ADDR_RESET    = 7'h1B;
    localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
    localparam logic [3:0] BITS_PER_BYTE     = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK
    } isib_state_t;
endpackage
`default_nettype wire

// File: isib_line_monitor.sv
// module: synchronises scl/sda and finds scl edges, start and stop conditions
`timescale 1ns/1ns
`default_nettype none
module isib_line_monitor (
    input  wire logic ref_clk_in,
    input  wire logic rst_in,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_out,
    output logic      scl_rise_out,
    output logic      scl_fall_out,
    output logic      start_out,
    output logic      stop_out
);
    logic [1:0] scl_meta_q;
    logic [1:0] sda_meta_q;
    logic       scl_prev_q;
    logic       sda_prev_q;

    // two-stage synchronisers; stage 0 feeds only stage 1
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            scl_meta_q <= 2'h3;
            sda_meta_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_meta_q <= {scl_meta_q[0], scl_in};
            sda_meta_q <= {sda_meta_q[0], sda_in};
            scl_prev_q <= scl_meta_q[1];
            sda_prev_q <= sda_meta_q[1];
        end
    end

    assign scl_out      = scl_meta_q[1];
    assign sda_out      = sda_meta_q[1];
    assign scl_rise_out = scl_meta_q[1] & ~scl_prev_q;
    assign scl_fall_out = ~scl_meta_q[1] & scl_prev_q;
    // sda moving while scl stays high marks start or stop
    assign start_out    = scl_meta_q[1] & scl_prev_q & ~sda_meta_q[1] & sda_prev_q;
    assign stop_out     = scl_meta_q[1] & scl_prev_q & sda_meta_q[1] & ~sda_prev_q;
endmodule // isib_line_monitor
`default_nettype wire

// File: isib_slave_top.sv
// module: i2c slave with irq enables, own address and data buffer behind avalon-mm
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module isib_slave_top (
    input  wire logic                         ref_clk_in,
    input  wire logic                         rst_in,
    input  wire logic [isib_pkg::ADDR_W-1:0]  avs_address_in,
    input  wire logic                         avs_read_in,
    input  wire logic                         avs_write_in,
    input  wire logic [isib_pkg::DATA_W-1:0]  avs_writedata_in,
    output logic      [isib_pkg::DATA_W-1:0]  avs_readdata_out,
    output logic                              avs_waitrequest_out,
    input  wire logic                         scl_in,
    output logic                              scl_out,
    output logic                              scl_oe_out,
    input  wire logic                         sda_in,
    output logic                              sda_out,
    output logic                              sda_oe_out,
    input  wire logic                         bus_timeout_event_in,
    output logic                              irq_out
);
    import isib_pkg::*;

    // line events
    logic scl_s;
    logic sda_s;
    logic scl_rise_p;
    logic scl_fall_p;
    logic start_p;
    logic stop_p;

    isib_line_monitor u_line_monitor (
        .ref_clk_in   (ref_clk_in),
        .rst_in       (rst_in),
        .scl_in       (scl_in),
        .sda_in       (sda_in),
        .scl_out      (scl_s),
        .sda_out      (sda_s),
        .scl_rise_out (scl_rise_p),
        .scl_fall_out (scl_fall_p),
        .start_out    (start_p),
        .stop_out     (stop_p)
    );

    // registers
    isib_state_t        state_q, state_d;
    logic [3:0]         cnt_q, cnt_d;
    logic [7:0]         shift_q, shift_d;
    logic               sda_drv_q, sda_drv_d;
    logic               transfer_direction_q, transfer_direction_d;
    logic [7:0]         rx_data_q, rx_data_d;
    logic [7:0]         tx_data_q;
    logic [6:0]         own_addr_q;
    logic [REG_W-1:0]   slave_irq_enable_q;
    logic [2:0]         control_q;
    logic [REG_W-1:0]   flag_q, flag_d;
    logic               bus_busy_q;
    logic               rx_unread_q;
    logic               wait_q;
    logic [DATA_W-1:0]  rdata_q;
    logic               irq_q;
    logic               scl_hold_q;

    // engine events
    logic ev_start;
    logic ev_stop;
    logic ev_am;
    logic ev_gc;
    logic ev_rx;
    logic ev_tx;
    logic ev_nack;
    logic ev_ack;
    logic ev_stretch;

    // bus decode
    wire        req          = avs_read_in | avs_write_in;
    wire        acc          = req & ~wait_q;
    wire        sel_buf      = (avs_address_in == IDX_BUFFER);
    wire        sel_status   = (avs_address_in == IDX_STATUS);
    wire        sel_irq_en   = (avs_address_in == IDX_IRQ_EN);
    wire        sel_control  = (avs_address_in == IDX_CONTROL);
    wire        sel_own      = (avs_address_in == IDX_OWN_ADDR);
    wire        wr_acc       = avs_write_in & acc;
    wire        rd_buf       = avs_read_in & acc & sel_buf;
    wire [15:0] wdata16      = avs_writedata_in[REG_W-1:0];

    wire controller_active = (state_q != ST_IDLE) && (state_q != ST_ADDR);
    wire ack_value_select  = control_q[CTL_ACK];
    wire gc_enable         = control_q[CTL_GC_EN];
    wire stretch_enable    = control_q[CTL_STRETCH];

    wire addr_hit = (shift_q[7:1] == own_addr_q);
    wire gc_hit   = gc_enable && (shift_q[7:1] == GENERAL_CALL_ADDR);

    wire [15:0] status_word = {bus_busy_q, controller_active, flag_q[13:11], scl_s, flag_q[9:0]};
    wire [15:0] own_word    = {8'h00, own_addr_q, transfer_direction_q};
    wire [15:0] read_mux    = sel_buf     ? {8'h00, rx_data_q} :
                              sel_status  ? status_word :
                              sel_irq_en  ? slave_irq_enable_q :
                              sel_control ? {13'h0000, control_q} :
                              sel_own     ? own_word : 16'h0000;

    // byte engine
    always_comb begin
        state_d              = state_q;
        cnt_d                = cnt_q;
        shift_d              = shift_q;
        sda_drv_d            = sda_drv_q;
        transfer_direction_d = transfer_direction_q;
        rx_data_d            = rx_data_q;
        ev_start             = 1'b0;
        ev_stop              = 1'b0;
        ev_am                = 1'b0;
        ev_gc                = 1'b0;
        ev_rx                = 1'b0;
        ev_tx                = 1'b0;
        ev_nack              = 1'b0;
        ev_ack               = 1'b0;
        ev_stretch           = 1'b0;
        if (stop_p) begin
            state_d   = ST_IDLE;
            sda_drv_d = 1'b0;
            ev_stop   = 1'b1;
        end else if (start_p) begin
            state_d   = ST_ADDR;
            cnt_d     = 4'h0;
            sda_drv_d = 1'b0;
            ev_start  = 1'b1;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                end
                ST_ADDR: begin
                    if (scl_rise_p && cnt_q != BITS_PER_BYTE) begin
                        shift_d = {shift_q[6:0], sda_s};
                        cnt_d   = cnt_q + 4'h1;
                    end else if (scl_fall_p && cnt_q == BITS_PER_BYTE) begin
                        cnt_d = 4'h0;
                        if (addr_hit || gc_hit) begin
                            state_d              = ST_ADDR_ACK;
                            sda_drv_d            = ~ack_value_select;
                            transfer_direction_d = shift_q[0];
                            ev_am                = addr_hit;
                            ev_gc                = gc_hit;
                        end else begin
                            state_d = ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall_p) begin
                        ev_stretch = stretch_enable;
                        if (transfer_direction_q) begin
                            state_d   = ST_TX;
                            shift_d   = tx_data_q;
                            sda_drv_d = ~tx_data_q[7];
                        end else begin
                            state_d   = ST_RX;
                            sda_drv_d = 1'b0;
                        end
                    end
                end
                ST_RX: begin
                    if (scl_rise_p && cnt_q != BITS_PER_BYTE) begin
                        shift_d = {shift_q[6:0], sda_s};
                        cnt_d   = cnt_q + 4'h1;
                        if (cnt_q == BITS_PER_BYTE - 4'h1) begin
                            rx_data_d = {shift_q[6:0], sda_s};
                            ev_rx     = 1'b1;
                        end
                    end else if (scl_fall_p && cnt_q == BITS_PER_BYTE) begin
                        state_d   = ST_RX_ACK;
                        cnt_d     = 4'h0;
                        sda_drv_d = ~ack_value_select;
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall_p) begin
                        state_d    = ST_RX;
                        sda_drv_d  = 1'b0;
                        ev_stretch = stretch_enable;
                    end
                end
                ST_TX: begin
                    if (scl_fall_p) begin
                        if (cnt_q == BITS_PER_BYTE - 4'h1) begin
                            state_d   = ST_TX_ACK;
                            cnt_d     = 4'h0;
                            sda_drv_d = 1'b0;
                        end else begin
                            shift_d   = {shift_q[6:0], 1'b0};
                            sda_drv_d = ~shift_q[6];
                            cnt_d     = cnt_q + 4'h1;
                        end
                    end
                end
                ST_TX_ACK: begin
                    // shift_q[0] keeps the answer of the host until the ack clock ends
                    if (scl_rise_p) begin
                        shift_d[0] = sda_s;
                        ev_tx      = 1'b1;
                        ev_nack    = sda_s;
                        ev_ack     = ~sda_s;
                    end else if (scl_fall_p) begin
                        if (shift_q[0]) begin
                            state_d = ST_IDLE;
                        end else begin
                            state_d    = ST_TX;
                            shift_d    = tx_data_q;
                            sda_drv_d  = ~tx_data_q[7];
                            ev_stretch = stretch_enable;
                        end
                    end
                end
            endcase
        end
    end

    // flag update: hardware set wins over any clear in the same cycle
    logic [15:0] hw_set;
    logic [15:0] hw_clr;
    logic [15:0] sw_set;
    logic [15:0] sw_clr;
    wire         wr_status = wr_acc & sel_status;

    always_comb begin
        hw_set            = 16'h0000;
        hw_set[BIT_START] = ev_start;
        hw_set[BIT_STOP]  = ev_stop;
        hw_set[BIT_AM]    = ev_am;
        hw_set[BIT_GC]    = ev_gc;
        hw_set[BIT_RX]    = ev_rx;
        hw_set[BIT_ROV]   = ev_rx & rx_unread_q & ~rd_buf;
        hw_set[BIT_TX]    = ev_tx;
        hw_set[BIT_NACK]  = ev_nack;
        hw_set[BIT_STR]   = ev_stretch;
        hw_set[BIT_TO]    = bus_timeout_event_in;
        hw_clr            = 16'h0000;
        hw_clr[BIT_ROV]   = rd_buf;
        hw_clr[BIT_NACK]  = ev_ack;
        sw_set            = wr_status ? (wdata16 & FLAG_SW_SET_MASK) : 16'h0000;
        sw_clr            = wr_status ? (~wdata16 & FLAG_SW_CLR_MASK) : 16'h0000;
        flag_d            = (((flag_q & ~(sw_clr | hw_clr)) | sw_set) | hw_set) & EVENT_MASK;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q              <= ST_IDLE;
            cnt_q                <= 4'h0;
            shift_q              <= 8'h00;
            sda_drv_q            <= 1'b0;
            transfer_direction_q <= 1'b0;
            rx_data_q            <= 8'h00;
            flag_q               <= 16'h0000;
        end else begin
            state_q              <= state_d;
            cnt_q                <= cnt_d;
            shift_q              <= shift_d;
            sda_drv_q            <= sda_drv_d;
            transfer_direction_q <= transfer_direction_d;
            rx_data_q            <= rx_data_d;
            flag_q               <= flag_d;
        end
    end

    // bus status and unread-byte tracking
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            bus_busy_q  <= 1'b0;
            rx_unread_q <= 1'b0;
        end else begin
            if (start_p) begin
                bus_busy_q <= 1'b1;
            end else if (stop_p) begin
                bus_busy_q <= 1'b0;
            end
            if (ev_rx) begin
                rx_unread_q <= 1'b1;
            end else if (rd_buf) begin
                rx_unread_q <= 1'b0;
            end
        end
    end

    // software registers
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_data_q          <= 8'h00;
            own_addr_q         <= OWN_ADDR_RESET;
            slave_irq_enable_q <= 16'h0000;
            control_q          <= CONTROL_RESET;
        end else if (wr_acc) begin
            if (sel_buf && !controller_active) begin
                tx_data_q <= wdata16[7:0];
            end
            if (sel_own) begin
                own_addr_q <= wdata16[7:1];
            end
            if (sel_irq_en) begin
                slave_irq_enable_q <= wdata16 & EVENT_MASK;
            end
            if (sel_control) begin
                control_q <= wdata16[2:0];
            end
        end
    end

    // avalon answer: one wait cycle, then waitrequest low for the accepting edge
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            wait_q <= ~(req & wait_q);
            if (avs_read_in && wait_q) begin
                rdata_q <= {16'h0000, read_mux};
            end
        end
    end

    wire [15:0] irq_src = flag_q & slave_irq_enable_q;

    // interrupt and pin drivers
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_q      <= 1'b0;
            scl_hold_q <= 1'b0;
        end else begin
            irq_q      <= |irq_src;
            scl_hold_q <= flag_q[BIT_STR] & stretch_enable;
        end
    end

    assign avs_readdata_out    = rdata_q;
    assign avs_waitrequest_out = wait_q;
    assign irq_out             = irq_q;
    assign scl_oe_out          = scl_hold_q;
    assign sda_oe_out          = sda_drv_q;
    // open-drain lines only ever pull low
    assign scl_out             = 1'b0;
    assign sda_out             = 1'b0;
endmodule // isib_slave_top
`default_nettype wire

// File: isib_slave_checker.sv
// checker: port-level assertions for the i2c slave block
`timescale 1ns/1ns
`default_nettype none
module isib_slave_checker (
    input wire logic                        ref_clk_in,
    input wire logic                        rst_in,
    input wire logic [isib_pkg::ADDR_W-1:0] avs_address_in,
    input wire logic                        avs_read_in,
    input wire logic                        avs_write_in,
    input wire logic [isib_pkg::DATA_W-1:0] avs_writedata_in,
    input wire logic [isib_pkg::DATA_W-1:0] avs_readdata_out,
    input wire logic                        avs_waitrequest_out,
    input wire logic                        scl_in,
    input wire logic                        scl_out,
    input wire logic                        sda_out,
    input wire logic                        sda_oe_out,
    input wire logic                        irq_out
);
    import isib_pkg::*;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    wire rd_ack = avs_read_in && !avs_waitrequest_out;
    wire wr_ack = avs_write_in && !avs_waitrequest_out;
    wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low too long");
    req_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |-> ##[1:2] !avs_waitrequest_out) else $error("request not answered");
    no_req_wait_a: assert property (!avs_read_in && !avs_write_in |=> avs_waitrequest_out)
        else $error("answer without request");
    upper_zero_a: assert property (avs_readdata_out[31:16] == 16'h0000)
        else $error("upper read data not zero");
    en_reserved_a: assert property (rd_ack && avs_address_in == IDX_IRQ_EN
        |-> (avs_readdata_out[15:0] & ~EVENT_MASK) == 16'h0000) else $error("reserved enable bits set");
    addr_reserved_a: assert property (rd_ack && avs_address_in == IDX_OWN_ADDR
        |-> avs_readdata_out[15:8] == 8'h00) else $error("reserved address bits set");
    buf_reserved_a: assert property (rd_ack && avs_address_in == IDX_BUFFER
        |-> avs_readdata_out[15:8] == 8'h00) else $error("buffer upper byte set");
    irq_off_a: assert property (wr_ack && avs_address_in == IDX_IRQ_EN && avs_writedata_in[15:0] == 16'h0000
        |-> ##2 !irq_out) else $error("irq with all enables clear");
    open_drain_a: assert property (!scl_out && !sda_out) else $error("open drain output driven high");
    ack_low_scl_a: assert property ($rose(sda_oe_out) |-> !scl_in) else $error("sda driven while scl high");
    cover property (wr_ack && avs_address_in == IDX_IRQ_EN);
    cover property ($rose(sda_oe_out));
    cover property ($rose(irq_out));
endmodule // isib_slave_checker
bind isib_slave_top isib_slave_checker chk (.ref_clk_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .scl_in, .scl_out, .sda_out, .sda_oe_out, .irq_out);
`default_nettype wire

// File: isib_host_model.sv
// partner: behavioural i2c host master with pulled-up open-drain lines
`timescale 1ns/1ns
`default_nettype none
module isib_host_model (
    input  wire logic scl_oe_in,
    input  wire logic sda_oe_in,
    output logic      scl_line_out,
    output logic      sda_line_out
);
    logic scl_q = 1'b1;
    logic sda_q = 1'b1;
    // released lines float to the pull-up level
    assign scl_line_out = scl_q & ~scl_oe_in;
    assign sda_line_out = sda_q & ~sda_oe_in;
    // lines change by non-blocking assignment so the block's sampling edge sees the old level
    task automatic start_cond();
        #50 sda_q <= 1'b1;
        #150 scl_q <= 1'b1;
        #200 sda_q <= 1'b0;
        #200 scl_q <= 1'b0;
    endtask
    task automatic stop_cond();
        #50 sda_q <= 1'b0;
        #150 scl_q <= 1'b1;
        #200 sda_q <= 1'b1;
        #200;
    endtask
    task automatic bit_cycle(input logic b, output logic s);
        #50 sda_q <= b;
        #150 scl_q <= 1'b1;
        wait (scl_line_out);
        #200 s = sda_line_out;
        scl_q <= 1'b0;
    endtask
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(d[i], s);
        bit_cycle(1'b1, s);
        ack = ~s;
    endtask
    task automatic read_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(1'b1, d[i]);
        bit_cycle(nack, s);
    endtask
endmodule // isib_host_model
`default_nettype wire

// File: tb_i2c_slave_irq_addr_buffer.sv
// testbench: register, interrupt and i2c transfer tests of the slave block
`timescale 1ns/1ns
`default_nettype none
module tb_i2c_slave_irq_addr_buffer;
    import isib_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, scl_oe, sda_oe, scl_line, sda_line, irq;
    logic bus_timeout = 1'b0;
    logic [7:0] rx;
    int error_cnt = 0;
    int checked = 0;
    always #25 ref_clk_in = ~ref_clk_in;
    isib_slave_top DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .avs_address_in(avs_address),
        .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
        .avs_readdata_out(avs_readdata), .avs_waitrequest_out(avs_waitrequest), .scl_in(scl_line), .scl_out(),
        .scl_oe_out(scl_oe), .sda_in(sda_line), .sda_out(), .sda_oe_out(sda_oe),
        .bus_timeout_event_in(bus_timeout), .irq_out(irq));
    isib_host_model host (.scl_oe_in(scl_oe), .sda_oe_in(sda_oe), .scl_line_out(scl_line), .sda_line_out(sda_line));
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus_xfer(input logic wr_en, input logic [3:0] a, input logic [15:0] d, output logic [15:0] q);
        @(posedge ref_clk_in);
        avs_read <= ~wr_en;
        avs_write <= wr_en;
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        // only the watchdog ends a wait that never sees waitrequest low
        do begin
            @(posedge ref_clk_in);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata[15:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        logic [15:0] q;
        bus_xfer(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input string nm, input logic [3:0] a, input logic [15:0] mask, input logic [15:0] exp);
        logic [15:0] q;
        bus_xfer(1'b0, a, 16'h0000, q);
        check(nm, q & mask, exp);
    endtask
    task automatic irq_chk(input logic exp);
        repeat (3) @(posedge ref_clk_in);
        check("irq", {15'h0000, irq}, {15'h0000, exp});
    endtask
    task automatic send(input logic [7:0] d, input logic exp_ack);
        logic a;
        host.write_byte(d, a);
        check("ack", {15'h0000, a}, {15'h0000, exp_ack});
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #1_000_000;
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        rd_chk("buffer", IDX_BUFFER, 16'hFFFF, 16'h0000);
        rd_chk("irq_en", IDX_IRQ_EN, 16'hFFFF, 16'h0000);
        rd_chk("own_addr", IDX_OWN_ADDR, 16'hFFFF, {8'h00, OWN_ADDR_RESET, 1'b0});
        rd_chk("unmapped", 4'h7, 16'hFFFF, 16'h0000);
        wr(IDX_IRQ_EN, 16'hFFFF);
        rd_chk("irq_en", IDX_IRQ_EN, 16'hFFFF, EVENT_MASK);
        wr(IDX_IRQ_EN, 16'h0000);
        wr(IDX_OWN_ADDR, 16'h0085);
        rd_chk("own_addr", IDX_OWN_ADDR, 16'hFFFF, 16'h0084);
        // each software-settable flag: blocked, raised, blocked again
        for (int b = 0; b < REG_W; b++) if (FLAG_SW_SET_MASK[b]) begin
            wr(IDX_STATUS, 16'h0001 << b);
            irq_chk(1'b0);
            wr(IDX_IRQ_EN, 16'h0001 << b);
            irq_chk(1'b1);
            wr(IDX_IRQ_EN, 16'h0000);
            irq_chk(1'b0);
            wr(IDX_STATUS, 16'h0000);
            rd_chk("buffer", IDX_BUFFER, 16'hFF00, 16'h0000);
            rd_chk("flags", IDX_STATUS, EVENT_MASK, 16'h0000);
        end
        @(posedge ref_clk_in) bus_timeout <= 1'b1;
        @(posedge ref_clk_in) bus_timeout <= 1'b0;
        rd_chk("timeout", IDX_STATUS, 16'h0010, 16'h0010);
        wr(IDX_STATUS, 16'h0000);
        host.start_cond();
        send(8'h84, 1'b1);
        send(8'hA5, 1'b1);
        rd_chk("status", IDX_STATUS, 16'h4225, 16'h4025);
        send(8'h5A, 1'b1);
        rd_chk("overrun", IDX_STATUS, 16'h0200, 16'h0200);
        rd_chk("rx byte", IDX_BUFFER, 16'hFFFF, 16'h005A);
        rd_chk("overrun", IDX_STATUS, 16'h0200, 16'h0000);
        host.stop_cond();
        rd_chk("stop", IDX_STATUS, 16'h4800, 16'h0800);
        wr(IDX_IRQ_EN, 16'h0004);
        irq_chk(1'b1);
        wr(IDX_STATUS, 16'h0000);
        irq_chk(1'b0);
        wr(IDX_IRQ_EN, 16'h0080);
        wr(IDX_BUFFER, 16'h0096);
        host.start_cond();
        send(8'h85, 1'b1);
        rd_chk("own_addr", IDX_OWN_ADDR, 16'hFFFF, 16'h0085);
        wr(IDX_BUFFER, 16'h003C);
        host.read_byte(1'b1, rx);
        check("tx byte", {8'h00, rx}, 16'h0096);
        // let the block see the last clock fall before asking for its state
        repeat (4) @(posedge ref_clk_in);
        rd_chk("nack", IDX_STATUS, 16'h4082, 16'h0082);
        irq_chk(1'b1);
        host.stop_cond();
        wr(IDX_IRQ_EN, 16'h0000);
        wr(IDX_STATUS, 16'h0000);
        host.start_cond();
        send(8'h22, 1'b0);
        host.stop_cond();
        // general call with clock stretching enabled
        wr(IDX_CONTROL, 16'h0006);
        wr(IDX_IRQ_EN, 16'h0008);
        host.start_cond();
        send(8'h00, 1'b1);
        repeat (4) @(posedge ref_clk_in);
        rd_chk("gen call", IDX_STATUS, 16'h0128, 16'h0108);
        irq_chk(1'b1);
        check("scl hold", {15'h0000, scl_oe}, 16'h0001);
        wr(IDX_STATUS, 16'h0000);
        irq_chk(1'b0);
        check("scl hold", {15'h0000, scl_oe}, 16'h0000);
        host.stop_cond();
        summarize();
    end
endmodule // tb_i2c_slave_irq_addr_buffer
`default_nettype wire
